// ---- rtl/fppr_pkg.sv ----
// Constants and types shared by the front panel power and reset controller
package fppr_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = CYC_PER_MS * DEBOUNCE_MS;
	localparam int PULSE_MIN_MS = 5;
	localparam int PULSE_MIN_CYC = CYC_PER_MS * PULSE_MIN_MS;
	localparam int PULSE_MAX_MS = 100;
	localparam int PULSE_MAX_CYC = CYC_PER_MS * PULSE_MAX_MS;
	localparam int I2C_RST_US = 100;
	localparam int I2C_RST_CYC = CYC_PER_US * I2C_RST_US;
	localparam int RESTORE_CYC = 4;
	localparam logic [6:0] I2C_ADDR = 7'h51;
	localparam logic [7:0] REG_FAULT = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h01;
	localparam int FLT_PSU_BIT = 0;
	localparam int FLT_DRV_BIT = 1;
	localparam int ST_COOL_BIT = 2;
	localparam int ST_PWR_BIT = 3;
	localparam int CMD_RST_BIT = 0;
	localparam logic PWR_RESET_VAL = 1'b0;
	typedef enum logic [1:0] {PS_INIT, PS_RUN} fppr_pstate_t;
	typedef enum logic [3:0] {
		IS_IDLE, IS_ADDR, IS_AACK, IS_PTR, IS_PACK, IS_WDAT, IS_WACK, IS_RDAT, IS_RACK
	} fppr_istate_t;
endpackage : fppr_pkg

// ---- rtl/fppr_debounce.sv ----
// Synchroniser and debouncer for one pushbutton
`timescale 1ns/100ps
`default_nettype none
module fppr_debounce #(
	parameter int CYCLES = fppr_pkg::DEBOUNCE_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic raw_in,
	output logic stable_out
);
	import fppr_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	typedef struct packed {
		logic s1;
		logic s2;
		logic stable;
		logic [CW-1:0] cnt;
	} fppr_deb_t;
	fppr_deb_t q, d;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.s1 = raw_in;
		d.s2 = q.s1;
		if (q.s2 != q.stable) begin
			// Level must hold for the full window before it is taken
			if (q.cnt == CW'(CYCLES - 1)) begin // R1
				d.stable = q.s2;
				d.cnt = '0;
			end else begin
				d.cnt = q.cnt + CW'(1);
			end
		end else begin
			d.cnt = '0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign stable_out = q.stable;
endmodule : fppr_debounce
`default_nettype wire

// ---- rtl/fppr_i2c_slave.sv ----
// Small I2C slave: pointer byte then data bytes, reads return one status byte
`timescale 1ns/100ps
`default_nettype none
module fppr_i2c_slave (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_out,
	input wire logic [7:0] rd_data_in,
	output logic wr_stb_out,
	output logic [7:0] wr_ptr_out,
	output logic [7:0] wr_dat_out
);
	import fppr_pkg::*;
	typedef struct packed {
		logic c1, c2, cp, a1, a2, ap;
		fppr_istate_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic oe;
		logic stb;
		logic [7:0] dat;
	} fppr_i2c_t;
	fppr_i2c_t q, d;
	logic rise, fall, start, stop;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.stb = 1'b0;
		d.c1 = scl_in;
		d.c2 = q.c1;
		d.cp = q.c2;
		d.a1 = sda_in;
		d.a2 = q.a1;
		d.ap = q.a2;
		rise = q.c2 & !q.cp;
		fall = !q.c2 & q.cp;
		start = q.c2 & q.cp & q.ap & !q.a2;
		stop = q.c2 & q.cp & !q.ap & q.a2;
		if (start) begin
			d.st = IS_ADDR;
			d.cnt = '0;
			d.oe = 1'b0;
		end else if (stop) begin
			d.st = IS_IDLE;
			d.oe = 1'b0;
		end else if (rise) begin
			case (q.st)
				IS_ADDR, IS_PTR, IS_WDAT: begin
					d.sh = {q.sh[6:0], q.a2};
					d.cnt = q.cnt + 4'h1;
				end
				IS_RDAT: d.cnt = q.cnt + 4'h1;
				IS_RACK: d.st = q.a2 ? IS_IDLE : IS_AACK;
				default: d.st = q.st;
			endcase
		end else if (fall) begin
			case (q.st)
				IS_ADDR: if (q.cnt == 4'h8) begin
					// Only the own address is acknowledged
					if (q.sh[7:1] == I2C_ADDR) begin // R19
						d.oe = 1'b1;
						d.st = IS_AACK;
						d.sh = {7'h00, q.sh[0]};
					end else begin
						d.st = IS_IDLE;
					end
				end
				IS_AACK: begin
					d.cnt = '0;
					if (q.sh[0] || q.st == IS_AACK && q.cnt == 4'h8 && q.sh[0]) begin
						d.st = IS_RDAT;
						d.oe = !rd_data_in[7];
						d.sh = {rd_data_in[6:0], 1'b1};
					end else begin
						d.st = IS_PTR;
						d.oe = 1'b0;
					end
				end
				IS_PTR: if (q.cnt == 4'h8) begin
					d.ptr = q.sh;
					d.oe = 1'b1;
					d.st = IS_PACK;
				end
				IS_WDAT: if (q.cnt == 4'h8) begin
					d.stb = 1'b1;
					d.dat = q.sh;
					d.oe = 1'b1;
					d.st = IS_WACK;
				end
				IS_PACK, IS_WACK: begin
					d.oe = 1'b0;
					d.cnt = '0;
					d.st = IS_WDAT;
				end
				IS_RDAT: begin
					if (q.cnt == 4'h8) begin
						d.oe = 1'b0;
						d.st = IS_RACK;
					end else begin
						d.oe = !q.sh[7];
						d.sh = {q.sh[6:0], 1'b1};
					end
				end
				default: d.st = q.st;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '{st: IS_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end

	assign sda_oe_out = q.oe;
	assign wr_stb_out = q.stb;
	assign wr_ptr_out = q.ptr;
	assign wr_dat_out = q.dat;
endmodule : fppr_i2c_slave
`default_nettype wire

// ---- rtl/fppr_top.sv ----
// Front panel power, reset, interrupt and fault indicator controller
// What this block does
// [R1] Every pushbutton is synchronised and debounced before use.
// [R2] Each nmi button press gives exactly one interrupt pulse.
// [R3] Power button press while off always powers on.
// [R4] Power button press while on powers off unless secure mode.
// [R5] Releasing the power button never changes power state.
// [R6] Clock alarm request works in level or pulse mode by strap.
// [R7] Level mode: falling clock alarm request powers on.
// [R8] Level mode: rising clock alarm request powers off.
// [R9] Level mode reacts to edges only, never to static level.
// [R10] Baseboard holds clock alarm request at wanted level.
// [R11] Management low pulse toggles power; secure mode ignored.
// [R12] Management pulses between 5 ms and 100 ms are accepted.
// [R13] Power state kept in nonvolatile store and restored at start.
// [R14] Restore is automatic and ignores secure mode.
// [R15] Secure mode blocks power-off button and reset button only.
// [R16] No replay after secure mode; held power button then powers off.
// [R17] Reset button held without secure mode holds system reset.
// [R18] I2C reset command resets system regardless of secure mode.
// [R19] I2C slave answers at address A2h.
// [R20] I2C-written supply and drive faults light their LEDs.
// [R21] Cooling fail LED follows the active-low cooling fail input.
// [R22] Pulse mode: valid clock alarm low pulse toggles power.
`timescale 1ns/100ps
`default_nettype none
module fppr_top #(
	parameter int DEB_CYC = fppr_pkg::DEBOUNCE_CYC,
	parameter int PMIN_CYC = fppr_pkg::PULSE_MIN_CYC,
	parameter int PMAX_CYC = fppr_pkg::PULSE_MAX_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic power_button_n_in,
	input wire logic reset_button_n_in,
	input wire logic nmi_button_n_in,
	input wire logic rtc_power_n_in,
	input wire logic rtc_pulse_mode_in,
	input wire logic mgmt_power_n_in,
	input wire logic secure_mode_in,
	input wire logic cooling_fail_n_in,
	input wire logic nv_power_in,
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe_out,
	output logic power_on_out,
	output logic sys_reset_n_out,
	output logic nmi_out,
	output logic nv_wr_out,
	output logic nv_data_out,
	output logic power_on_led_out,
	output logic power_fail_led_out,
	output logic cooling_fail_led_out,
	output logic drive_fault_led_out
);
	import fppr_pkg::*;
	localparam int MCW = $clog2(PMAX_CYC + 2);
	localparam int RCW = $clog2(I2C_RST_CYC + 1);

	typedef struct packed {
		logic rtc_s1, rtc_s2, rtc_p;
		logic mg_s1, mg_s2, mg_p;
		logic sec_s1, sec_s2, sec_p;
		logic cool_s1, cool_s2;
		logic nv_s1, nv_s2;
		logic mode_s1, mode_s2;
		logic pb_p, nb_p;
		logic [MCW-1:0] mg_cnt;
		logic [MCW-1:0] rtc_cnt;
		fppr_pstate_t st;
		logic [2:0] init_cnt;
		logic power;
		logic nv_wr;
		logic nmi;
		logic [RCW-1:0] rst_cnt;
		logic sys_rst_n;
		logic psu_flt, drv_flt, cool_led;
		logic sda_lvl;
	} fppr_top_t;
	fppr_top_t q, d;

	logic pb, rb, nb;
	logic wr_stb;
	logic [7:0] wr_ptr, wr_dat, rd_data;
	logic pb_press, sec_fall, mg_rise, rtc_rise, rtc_fall;
	logic ev_pb_on, ev_pb_off, ev_mg, ev_rtc_on, ev_rtc_off, ev_rtc_tog;
	logic want_on, want_off;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [MCW-1:0] sat_inc(input logic [MCW-1:0] c);
		sat_inc = (c == MCW'(PMAX_CYC + 1)) ? c : c + MCW'(1);
	endfunction : sat_inc

	function automatic logic pulse_ok(input logic [MCW-1:0] c);
		pulse_ok = (c >= MCW'(PMIN_CYC)) && (c <= MCW'(PMAX_CYC));
	endfunction : pulse_ok

	////////////////////////////////////////////////////////////////////////////
	fppr_debounce #(.CYCLES(DEB_CYC)) u_deb_pwr (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.raw_in(!power_button_n_in),
		.stable_out(pb)
	);
	fppr_debounce #(.CYCLES(DEB_CYC)) u_deb_rst (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.raw_in(!reset_button_n_in),
		.stable_out(rb)
	);
	fppr_debounce #(.CYCLES(DEB_CYC)) u_deb_nmi (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.raw_in(!nmi_button_n_in),
		.stable_out(nb)
	);
	fppr_i2c_slave u_i2c (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.scl_in(i2c_scl_in),
		.sda_in(i2c_sda_in),
		.sda_oe_out(i2c_sda_oe_out),
		.rd_data_in(rd_data),
		.wr_stb_out(wr_stb),
		.wr_ptr_out(wr_ptr),
		.wr_dat_out(wr_dat)
	);

	always_comb begin
		rd_data = '0;
		rd_data[FLT_PSU_BIT] = q.psu_flt;
		rd_data[FLT_DRV_BIT] = q.drv_flt;
		rd_data[ST_COOL_BIT] = q.cool_led;
		rd_data[ST_PWR_BIT] = q.power;
	end

	////////////////////////////////////////////////////////////////////////////
	// Event decode
	always_comb begin
		pb_press = pb & !q.pb_p;
		sec_fall = q.sec_p & !q.sec_s2;
		mg_rise = q.mg_s2 & !q.mg_p;
		rtc_rise = q.rtc_s2 & !q.rtc_p;
		rtc_fall = !q.rtc_s2 & q.rtc_p;
		ev_pb_on = pb_press & !q.power; // R3
		ev_pb_off = q.power & !q.sec_s2 & (pb_press | (sec_fall & pb)); // R4 R5 R15 R16
		ev_mg = mg_rise & pulse_ok(q.mg_cnt); // R11 R12
		ev_rtc_on = !q.mode_s2 & rtc_fall; // R6 R7 R9
		ev_rtc_off = !q.mode_s2 & rtc_rise; // R8 R9
		ev_rtc_tog = q.mode_s2 & rtc_rise & pulse_ok(q.rtc_cnt); // R6 R22
		want_on = ev_pb_on | ev_rtc_on | ev_mg | ev_rtc_tog;
		want_off = ev_pb_off | ev_rtc_off | ev_mg | ev_rtc_tog;
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.rtc_s1 = rtc_power_n_in;
		d.rtc_s2 = q.rtc_s1;
		d.rtc_p = q.rtc_s2;
		d.mg_s1 = mgmt_power_n_in;
		d.mg_s2 = q.mg_s1;
		d.mg_p = q.mg_s2;
		d.sec_s1 = secure_mode_in;
		d.sec_s2 = q.sec_s1;
		d.sec_p = q.sec_s2;
		d.cool_s1 = cooling_fail_n_in;
		d.cool_s2 = q.cool_s1;
		d.nv_s1 = nv_power_in;
		d.nv_s2 = q.nv_s1;
		d.mode_s1 = rtc_pulse_mode_in;
		d.mode_s2 = q.mode_s1;
		d.pb_p = pb;
		d.nb_p = nb;
		d.sda_lvl = 1'b0;
		// Low time of the pulse-style requests
		d.mg_cnt = q.mg_s2 ? '0 : sat_inc(q.mg_cnt); // R12
		d.rtc_cnt = q.rtc_s2 ? '0 : sat_inc(q.rtc_cnt); // R22
		d.nmi = nb & !q.nb_p; // R2
		case (q.st)
			PS_INIT: begin
				// Stored state comes back with no one's help
				if (q.init_cnt == 3'(RESTORE_CYC)) begin
					d.power = q.nv_s2; // R13 R14
					d.st = PS_RUN;
				end else begin
					d.init_cnt = q.init_cnt + 3'h1;
				end
			end
			PS_RUN: begin
				if (!q.power && want_on) begin
					d.power = 1'b1;
				end else if (q.power && want_off) begin
					d.power = 1'b0;
				end
			end
			default: d.st = PS_INIT;
		endcase
		d.nv_wr = d.power != q.power; // R13
		if (wr_stb && wr_ptr == REG_FAULT) begin
			d.psu_flt = wr_dat[FLT_PSU_BIT]; // R20
			d.drv_flt = wr_dat[FLT_DRV_BIT]; // R20
		end
		if (wr_stb && wr_ptr == REG_CMD && wr_dat[CMD_RST_BIT]) begin
			d.rst_cnt = RCW'(I2C_RST_CYC); // R18
		end else if (q.rst_cnt != '0) begin
			d.rst_cnt = q.rst_cnt - RCW'(1);
		end
		d.sys_rst_n = !((rb & !q.sec_s2) | (d.rst_cnt != '0)); // R15 R17 R18
		d.cool_led = !q.cool_s2; // R21
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '{st: PS_INIT, power: PWR_RESET_VAL, sys_rst_n: 1'b1, rtc_s1: 1'b1,
				rtc_s2: 1'b1, rtc_p: 1'b1, mg_s1: 1'b1, mg_s2: 1'b1, mg_p: 1'b1,
				cool_s1: 1'b1, cool_s2: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign i2c_sda_out = q.sda_lvl;
	assign power_on_out = q.power;
	assign power_on_led_out = q.power;
	assign nv_data_out = q.power;
	assign nv_wr_out = q.nv_wr;
	assign sys_reset_n_out = q.sys_rst_n;
	assign nmi_out = q.nmi;
	assign power_fail_led_out = q.psu_flt;
	assign drive_fault_led_out = q.drv_flt;
	assign cooling_fail_led_out = q.cool_led;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_nmi_single: assert property (q.nmi |=> !q.nmi) // R2
		else $error("nmi pulse longer than one cycle");
	a_press_on: assert property (q.st == PS_RUN && ev_pb_on |=> q.power) // R3
		else $error("power press while off did not power on");
	a_secure_blocks: assert property (q.st == PS_RUN && q.power && pb_press && q.sec_s2
		&& !ev_mg && !ev_rtc_off && !ev_rtc_tog |=> q.power) // R4
		else $error("power press under secure mode powered off");
	a_release_noop: assert property (q.st == PS_RUN && $fell(pb)
		&& !(ev_mg | ev_rtc_on | ev_rtc_off | ev_rtc_tog) |=> $stable(q.power)) // R5
		else $error("button release changed power");
	a_rtc_fall_on: assert property (q.st == PS_RUN && !q.mode_s2 && rtc_fall && !q.power
		|=> q.power) // R7
		else $error("clock alarm fall did not power on");
	a_rtc_rise_off: assert property (q.st == PS_RUN && !q.mode_s2 && rtc_rise && q.power
		|=> !q.power) // R8
		else $error("clock alarm rise did not power off");
	a_mgmt_toggle: assert property (q.st == PS_RUN && ev_mg
		|=> q.power != $past(q.power)) // R11
		else $error("management pulse did not toggle power");
	a_nv_follows: assert property ($changed(q.power) |-> q.nv_wr) // R13
		else $error("power change not stored");
	a_unsecure_off: assert property (q.st == PS_RUN && q.power && sec_fall && pb
		|=> !q.power) // R16
		else $error("held button after secure removal did not power off");
	a_reset_held: assert property (rb && !q.sec_s2 |=> !q.sys_rst_n) // R17
		else $error("reset button did not hold reset");
	a_i2c_reset: assert property (wr_stb && wr_ptr == REG_CMD && wr_dat[CMD_RST_BIT]
		|=> !q.sys_rst_n ##1 !q.sys_rst_n) // R18
		else $error("i2c reset command did not reset");
	a_fault_led: assert property (wr_stb && wr_ptr == REG_FAULT
		|=> q.psu_flt == $past(wr_dat[FLT_PSU_BIT])) // R20
		else $error("supply fault led not updated");
	a_cool_led: assert property (!q.cool_s2 |=> q.cool_led) // R21
		else $error("cooling fail led not lit");

	a_cool_clear: assert property (q.cool_s2 |=> !q.cool_led) // R21
		else $error("cooling fail led lit without failure");

	a_nmi_press: assert property (nb && !q.nb_p |=> q.nmi) // R2
		else $error("nmi press gave no pulse");

	a_nmi_debounced: assert property (!nb |=> !q.nmi) // R1
		else $error("nmi pulse without debounced press");

	a_press_off: assert property (q.st == PS_RUN && q.power && pb_press && !q.sec_s2
		|=> !q.power) // R4
		else $error("power press while on did not power off");

	a_secure_reset: assert property (q.sec_s2 && q.rst_cnt == '0 && !wr_stb
		|=> q.sys_rst_n) // R15
		else $error("reset button acted under secure mode");

	a_reset_release: assert property (!rb && q.rst_cnt == '0 && !wr_stb
		|=> q.sys_rst_n) // R17
		else $error("reset held after button release");

	a_i2c_reset_hold: assert property (q.rst_cnt > RCW'(1) |=> !q.sys_rst_n) // R18
		else $error("i2c reset released early");

	a_level_static: assert property (q.st == PS_RUN && !q.mode_s2 && !rtc_fall && !rtc_rise
		&& !ev_pb_on && !ev_pb_off && !ev_mg |=> $stable(q.power)) // R9
		else $error("static alarm level changed power");

	a_rtc_on_stays: assert property (q.st == PS_RUN && !q.mode_s2 && rtc_fall && q.power
		&& !ev_pb_off && !ev_mg |=> q.power) // R9
		else $error("alarm fall while on powered off");

	a_pulse_toggle: assert property (q.st == PS_RUN && ev_rtc_tog
		|=> q.power != $past(q.power)) // R22
		else $error("alarm pulse did not toggle power");

	a_pulse_refuse: assert property (q.st == PS_RUN && q.mode_s2 && rtc_rise
		&& !pulse_ok(q.rtc_cnt) && !ev_mg && !ev_pb_on && !ev_pb_off
		|=> $stable(q.power)) // R22
		else $error("bad alarm pulse changed power");

	a_mgmt_refuse: assert property (q.st == PS_RUN && mg_rise && !pulse_ok(q.mg_cnt)
		&& !ev_pb_on && !ev_pb_off && !ev_rtc_on && !ev_rtc_off && !ev_rtc_tog
		|=> $stable(q.power)) // R12
		else $error("bad management pulse changed power");

	a_mgmt_secure: assert property (q.st == PS_RUN && q.power && q.sec_s2 && ev_mg
		|=> !q.power) // R11
		else $error("secure mode blocked management power-off");

	a_restore: assert property (q.st == PS_INIT && q.init_cnt == 3'(RESTORE_CYC)
		|=> q.power == $past(q.nv_s2) && q.st == PS_RUN) // R13 R14
		else $error("stored power state not restored");

	a_init_quiet: assert property (q.st == PS_INIT && q.init_cnt != 3'(RESTORE_CYC)
		|=> $stable(q.power)) // R13
		else $error("power changed before restore");

	a_nv_quiet: assert property (!$changed(q.power) |-> !q.nv_wr) // R13
		else $error("store written without power change");

	a_drive_led: assert property (wr_stb && wr_ptr == REG_FAULT
		|=> q.drv_flt == $past(wr_dat[FLT_DRV_BIT])) // R20
		else $error("drive fault led not updated");
endmodule : fppr_top
`default_nettype wire

// ---- bench/fppr_partner.sv ----
// Behavioural far side: management card, clock alarm line and I2C master
`timescale 1ns/100ps
`default_nettype none
module fppr_partner (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out,
	output logic mgmt_n_out,
	output logic rtc_n_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		mgmt_n_out = 1'b1;
		rtc_n_out = 1'b1;
	end
	////////////////////////////////////////
	// Wait n cycles
	task automatic hw(input int n);
		repeat (n) @(negedge clk_in);
	endtask : hw
	// Low pulse of n cycles on the management or alarm line
	task automatic low_pulse(input logic alarm, input int n);
		if (alarm) begin
			rtc_n_out <= 1'b0;
		end else begin
			mgmt_n_out <= 1'b0;
		end
		hw(n);
		if (alarm) begin
			rtc_n_out <= 1'b1;
		end else begin
			mgmt_n_out <= 1'b1;
		end
	endtask : low_pulse
	// Alarm line held at the wanted level
	task automatic rtc_level(input logic v);
		rtc_n_out <= v;
		hw(20);
	endtask : rtc_level
	////////////////////////////////////////
	// One SCL period, SDA sampled while SCL high
	task automatic clk_bit(input logic b, output logic s);
		sda_low_out <= !b;
		hw(5);
		scl_out <= 1'b1;
		hw(3);
		s = sda_in;
		hw(2);
		scl_out <= 1'b0;
	endtask : clk_bit
	// Start, address, pointer, data, stop; ack is the address ack bit
	task automatic i2c_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
			output logic ack);
		logic [23:0] w;
		logic s;
		w = {a, p, d};
		sda_low_out <= 1'b1;
		hw(5);
		scl_out <= 1'b0;
		for (int i = 0; i < 27; i++) begin
			if (i % 9 == 8) begin
				clk_bit(1'b1, s);
			end else begin
				clk_bit(w[23 - (i - i / 9)], s);
			end
			if (i == 8) begin
				ack = s;
			end
		end
		sda_low_out <= 1'b1;
		hw(5);
		scl_out <= 1'b1;
		hw(5);
		sda_low_out <= 1'b0;
		hw(5);
	endtask : i2c_write
endmodule : fppr_partner
`default_nettype wire

// ---- bench/fppr_top_tb.sv ----
// Self-checking bench for the front panel power and reset controller
`timescale 1ns/100ps
`default_nettype none
module fppr_top_tb;
	import fppr_pkg::*;
	localparam int DEB = 8;
	localparam int PMIN = 10;
	localparam int PMAX = 40;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic pwr_btn_n = 1'b1;
	logic rst_btn_n = 1'b1;
	logic nmi_btn_n = 1'b1;
	logic pmode = 1'b0;
	logic secure = 1'b1;
	logic cool_n = 1'b1;
	logic nv_power = 1'b1;
	logic scl, sda_low, mgmt_n, rtc_n, sda_oe, ack;
	logic power_on, sys_reset_n, nmi, pfail_led, cool_led, drv_led;
	logic nv_wr, nv_data, pled, sda_lvl;
	wire sda = !(sda_low | sda_oe);
	logic sb[$];
	logic pstate = 1'b0;
	logic seen_pwr = 1'b0;
	int n_mismatch = 0;
	int checks = 0;
	int nmi_cnt = 0;
	int wd[5];
	logic [31:0] rng = 32'h0000ac5b;
	fppr_top #(.DEB_CYC(DEB), .PMIN_CYC(PMIN), .PMAX_CYC(PMAX)) i_fppr_top (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .power_button_n_in(pwr_btn_n),
		.reset_button_n_in(rst_btn_n), .nmi_button_n_in(nmi_btn_n), .rtc_power_n_in(rtc_n),
		.rtc_pulse_mode_in(pmode), .mgmt_power_n_in(mgmt_n), .secure_mode_in(secure),
		.cooling_fail_n_in(cool_n), .nv_power_in(nv_power), .i2c_scl_in(scl),
		.i2c_sda_in(sda), .i2c_sda_out(sda_lvl), .i2c_sda_oe_out(sda_oe),
		.power_on_out(power_on), .sys_reset_n_out(sys_reset_n), .nmi_out(nmi),
		.nv_wr_out(nv_wr), .nv_data_out(nv_data),
		.power_on_led_out(pled), .power_fail_led_out(pfail_led),
		.cooling_fail_led_out(cool_led), .drive_fault_led_out(drv_led));
	fppr_partner i_fppr_partner (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
		.sda_low_out(sda_low), .mgmt_n_out(mgmt_n), .rtc_n_out(rtc_n));
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic w(input int n);
		repeat (n) @(negedge clk_in);
	endtask : w
	task automatic note(input logic v);
		pstate = v;
		sb.push_back(v);
	endtask : note
	task automatic pwr(input logic v);
		pwr_btn_n <= v;
		w(DEB + 12);
	endtask : pwr
	////////////////////////////////////////
	// Power state watcher against the noted expectations
	always @(negedge clk_in) begin
		if (power_on !== seen_pwr) begin
			seen_pwr = power_on;
			check(8'(nv_wr), 8'h01);
			check(8'(nv_data), 8'(power_on));
			check(8'(pled), 8'(power_on));
			if (sb.size() == 0) begin
				check(8'(power_on), 8'(!power_on));
			end else begin
				check(8'(power_on), 8'(sb.pop_front()));
			end
		end
		if (nmi === 1'b1) begin
			nmi_cnt++;
		end
	end
	initial begin
		#3_000_000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		note(1'b1);
		w(3);
		rst_n_in <= 1'b1;
		w(20);
		$display("test restore done");
		pwr(1'b0);
		pwr(1'b1);
		secure <= 1'b0;
		w(20);
		secure <= 1'b1;
		note(1'b0);
		pwr(1'b0);
		secure <= 1'b0;
		w(20);
		pwr(1'b1);
		secure <= 1'b1;
		note(1'b1);
		pwr(1'b0);
		pwr(1'b1);
		secure <= 1'b0;
		note(1'b0);
		pwr(1'b0);
		pwr(1'b1);
		$display("test power button done");
		secure <= 1'b1;
		rng = xs(rng);
		wd = '{5, PMIN, PMAX, PMAX + 20, PMIN + int'(rng % (PMAX - PMIN + 1))};
		foreach (wd[i]) begin
			if (wd[i] >= PMIN && wd[i] <= PMAX) begin
				note(!pstate);
			end
			i_fppr_partner.low_pulse(1'b0, wd[i]);
			w(12);
		end
		$display("test management done");
		if (!pstate) note(1'b1);
		i_fppr_partner.rtc_level(1'b0);
		note(!pstate);
		i_fppr_partner.low_pulse(1'b0, 20);
		w(12);
		if (pstate) note(1'b0);
		i_fppr_partner.rtc_level(1'b1);
		note(1'b1);
		i_fppr_partner.rtc_level(1'b0);
		note(1'b0);
		i_fppr_partner.rtc_level(1'b1);
		pmode <= 1'b1;
		w(5);
		for (int i = 0; i < 3; i++) begin
			if (i < 2) note(!pstate);
			i_fppr_partner.low_pulse(1'b1, i < 2 ? PMIN + 10 * i : 5);
			w(12);
		end
		$display("test clock alarm done");
		nmi_cnt = 0;
		nmi_btn_n <= 1'b0;
		w(3);
		nmi_btn_n <= 1'b1;
		w(DEB + 12);
		check(8'(nmi_cnt), 8'h00);
		nmi_btn_n <= 1'b0;
		w(40);
		nmi_btn_n <= 1'b1;
		w(DEB + 12);
		check(8'(nmi_cnt), 8'h01);
		secure <= 1'b0;
		rst_btn_n <= 1'b0;
		w(DEB + 40);
		check(8'(sys_reset_n), 8'h00);
		rst_btn_n <= 1'b1;
		w(DEB + 12);
		check(8'(sys_reset_n), 8'h01);
		secure <= 1'b1;
		rst_btn_n <= 1'b0;
		w(DEB + 12);
		check(8'(sys_reset_n), 8'h01);
		rst_btn_n <= 1'b1;
		$display("test buttons done");
		i_fppr_partner.i2c_write(8'ha2, REG_FAULT, 8'h03, ack);
		check(8'(ack), 8'h00);
		check({6'h00, drv_led, pfail_led}, 8'h03);
		i_fppr_partner.i2c_write(8'ha4, REG_FAULT, 8'h00, ack);
		check(8'(ack), 8'h01);
		i_fppr_partner.i2c_write(8'ha2, REG_FAULT, 8'h02, ack);
		check({6'h00, drv_led, pfail_led}, 8'h02);
		i_fppr_partner.i2c_write(8'ha2, REG_CMD, 8'h01, ack);
		check(8'(sys_reset_n), 8'h00);
		w(I2C_RST_CYC);
		check(8'(sys_reset_n), 8'h01);
		cool_n <= 1'b0;
		w(5);
		check(8'(cool_led), 8'h01);
		cool_n <= 1'b1;
		w(5);
		check(8'(cool_led), 8'h00);
		$display("test i2c and leds done");
		check(8'(sb.size()), 8'h00);
		check(8'(sda_lvl), 8'h00);
		tally_and_finish();
	end
endmodule : fppr_top_tb
`default_nettype wire
